// *** rtl/agmd_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "agmd_regs.svh"
module agmd_top (
  input wire logic clk_in, // 200 MHz clock
  input wire logic rst_in, // Sync reset, active high
  input wire logic en_in, // Clock enable
  input wire logic we_in, // Write strobe from control port
  input wire logic re_in, // Read strobe from control port
  input wire logic [7:0] addr_in, // Register slot
  input wire logic [7:0] wdata_in, // Write data
  input wire logic headset_in, // Headset detect level (async)
  output logic [7:0] rdata_out, // Read data, held
  output logic rvalid_out, // Read data valid pulse
  output logic l_mute_out, // Left gain stage muted
  output logic [6:0] l_gain_out, // Left effective gain code
  output logic r_mute_out, // Right gain stage muted
  output logic [6:0] r_gain_out, // Right effective gain code
  output logic [3:0] conn_out, // Connects: Lmic>L, Rmic>L, Lmic>R, Rmic>R
  output logic [15:0] atten_out, // Attenuation steps, same order, 4 bits each
  output logic ac_coupled_out, // High-power outputs ac-coupled
  output logic full_diff_out, // Fully differential arrangement
  output logic pseudo_diff_out // Pseudodifferential arrangement
);
  agmd_wr_if wr (); // Write carrier
  logic [7:0] lgain, rgain, lmix, rmix, drv, rsvd; // Stored registers
  logic hs_meta_ff, hs_sync_ff; // Headset synchroniser
  logic [7:0] rdata_ff, nxt_rdata; // Read data register
  logic rvalid_ff, nxt_rvalid; // Read valid register
  logic [7:0] ctl_ff, nxt_ctl; // Mute and driver outputs
  logic [6:0] lg_ff, rg_ff, nxt_lg, nxt_rg; // Effective gain codes
  logic [3:0] conn_ff, nxt_conn; // Connect flags
  logic [15:0] att_ff, nxt_att; // Attenuation steps
  agmd_pkg::agmd_level_t lvl [0:3]; // Decoded levels
  logic [3:0] codes [0:3]; // Level fields

  // Gain clamp used for both channels
  function automatic logic [6:0] sat_gain(input logic [6:0] code);
    if (code > `AGMD_GAIN_SAT) begin
      return `AGMD_GAIN_SAT;
    end
    return code;
  endfunction

  assign wr.we = we_in;
  assign wr.addr = addr_in;
  assign wr.data = wdata_in;

  // Writable storage
  agmd_regfile u_regs (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .en_in(en_in),
    .wr(wr),
    .lgain_out(lgain),
    .rgain_out(rgain),
    .lmix_out(lmix),
    .rmix_out(rmix),
    .drv_out(drv),
    .rsvd_out(rsvd)
  );

  assign codes[0] = lmix[`AGMD_LEFT_LVL_MSB:`AGMD_LEFT_LVL_LSB];
  assign codes[1] = lmix[`AGMD_RIGHT_LVL_MSB:`AGMD_RIGHT_LVL_LSB];
  assign codes[2] = rmix[`AGMD_LEFT_LVL_MSB:`AGMD_LEFT_LVL_LSB];
  assign codes[3] = rmix[`AGMD_RIGHT_LVL_MSB:`AGMD_RIGHT_LVL_LSB];

  // One decoder per level field
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dec
      agmd_level_dec u_dec (
        .code_in(codes[g]),
        .lvl_out(lvl[g])
      );
    end
  endgenerate

  // Headset flag passes two flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hs_meta_ff <= 1'h0;
      hs_sync_ff <= 1'h0;
    end else if (en_in) begin
      hs_meta_ff <= headset_in;
      hs_sync_ff <= hs_meta_ff;
    end
  end

  // Read mux and control outputs
  always_comb begin
    nxt_rvalid = re_in;
    nxt_rdata = rdata_ff;
    if (re_in) begin
      unique case (addr_in)
        `AGMD_ADDR_RESERVED: nxt_rdata = rsvd;
        `AGMD_ADDR_DRIVER: begin
          nxt_rdata = drv;
          nxt_rdata[`AGMD_HEADSET_BIT] = hs_sync_ff;
        end
        `AGMD_ADDR_LGAIN: nxt_rdata = lgain;
        `AGMD_ADDR_RGAIN: nxt_rdata = rgain;
        `AGMD_ADDR_LMIX: nxt_rdata = lmix;
        `AGMD_ADDR_RMIX: nxt_rdata = rmix;
        default: nxt_rdata = 8'h00;
      endcase
    end
    nxt_ctl = 8'h00;
    nxt_ctl[0] = lgain[`AGMD_MUTE_BIT];
    nxt_ctl[1] = rgain[`AGMD_MUTE_BIT];
    nxt_ctl[2] = drv[`AGMD_COUPLE_BIT];
    nxt_ctl[3] = drv[`AGMD_FULLDIFF_BIT];
    nxt_ctl[4] = drv[`AGMD_PSEUDO_BIT];
    nxt_lg = sat_gain(lgain[`AGMD_GAIN_MSB:0]);
    nxt_rg = sat_gain(rgain[`AGMD_GAIN_MSB:0]);
    for (int i = 0; i < 4; i++) begin
      nxt_conn[i] = lvl[i].connect;
      nxt_att[i*4 +: 4] = lvl[i].atten_steps;
    end
  end

  // Output registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'h0;
      ctl_ff <= 8'h03;
      lg_ff <= 7'h00;
      rg_ff <= 7'h00;
      conn_ff <= 4'h0;
      att_ff <= 16'h8888;
    end else if (en_in) begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      ctl_ff <= nxt_ctl;
      lg_ff <= nxt_lg;
      rg_ff <= nxt_rg;
      conn_ff <= nxt_conn;
      att_ff <= nxt_att;
    end
  end

  assign rdata_out = rdata_ff;
  assign rvalid_out = rvalid_ff;
  assign l_mute_out = ctl_ff[0];
  assign r_mute_out = ctl_ff[1];
  assign ac_coupled_out = ctl_ff[2];
  assign full_diff_out = ctl_ff[3];
  assign pseudo_diff_out = ctl_ff[4];
  assign l_gain_out = lg_ff;
  assign r_gain_out = rg_ff;
  assign conn_out = conn_ff;
  assign atten_out = att_ff;
endmodule
`default_nettype wire

// *** inc/agmd_regs.svh ***
`ifndef AGMD_REGS_SVH
`define AGMD_REGS_SVH
// Register slots on the control port
`define AGMD_ADDR_RESERVED 8'h0D
`define AGMD_ADDR_DRIVER 8'h0E
`define AGMD_ADDR_LGAIN 8'h0F
`define AGMD_ADDR_RGAIN 8'h10
`define AGMD_ADDR_LMIX 8'h11
`define AGMD_ADDR_RMIX 8'h12
// Field positions
`define AGMD_MUTE_BIT 7
`define AGMD_GAIN_MSB 6
`define AGMD_LEFT_LVL_MSB 7
`define AGMD_LEFT_LVL_LSB 4
`define AGMD_RIGHT_LVL_MSB 3
`define AGMD_RIGHT_LVL_LSB 0
`define AGMD_COUPLE_BIT 7
`define AGMD_FULLDIFF_BIT 6
`define AGMD_HEADSET_BIT 4
`define AGMD_PSEUDO_BIT 3
// Reset values
`define AGMD_RST_GAIN 8'h80
`define AGMD_RST_MIX 8'hFF
`define AGMD_RST_DRIVER 8'h00
`define AGMD_RST_RESERVED 8'h00
// Codes
`define AGMD_GAIN_SAT 7'h77
`define AGMD_LVL_OFF 4'hF
`define AGMD_LVL_MAX 4'h8
// Writable mask of the driver register
`define AGMD_DRIVER_WMASK 8'hC8
`endif

// *** inc/agmd_pkg.sv ***
package agmd_pkg;
  // Control port access type
  typedef enum logic [1:0] {
    AGMD_IDLE = 2'h0,
    AGMD_WRITE = 2'h1,
    AGMD_READ = 2'h3
  } agmd_op_t;
  // Decoded level of one aux mic input
  typedef struct packed {
    logic connect;
    logic [3:0] atten_steps;
  } agmd_level_t;
endpackage

// *** inc/agmd_wr_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Write strobe with address and data shared between top and register file
interface agmd_wr_if;
  logic we;
  logic [7:0] addr;
  logic [7:0] data;
  modport src (output we, output addr, output data);
  modport dst (input we, input addr, input data);
endinterface
`default_nettype wire

// *** rtl/agmd_level_dec.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "agmd_regs.svh"
// Decodes one 4-bit level field into connect flag and attenuation steps
module agmd_level_dec (
  input wire logic [3:0] code_in, // Level field
  output var agmd_pkg::agmd_level_t lvl_out // Decoded level
);
  // Connect on any code below disconnect, clamp reserved codes to max
  always_comb begin
    lvl_out.connect = (code_in != `AGMD_LVL_OFF);
    if (code_in > `AGMD_LVL_MAX) begin
      lvl_out.atten_steps = `AGMD_LVL_MAX;
    end else begin
      lvl_out.atten_steps = code_in;
    end
  end
endmodule
`default_nettype wire

// *** rtl/agmd_regfile.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "agmd_regs.svh"
// Storage of the writable registers of the slice
module agmd_regfile (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Sync reset
  input wire logic en_in, // Clock enable
  agmd_wr_if.dst wr, // Write strobe
  output logic [7:0] lgain_out, // Left gain register
  output logic [7:0] rgain_out, // Right gain register
  output logic [7:0] lmix_out, // Left mixer levels
  output logic [7:0] rmix_out, // Right mixer levels
  output logic [7:0] drv_out, // Driver writable bits
  output logic [7:0] rsvd_out // Reserved slot
);
  logic [7:0] regs_ff [0:5]; // Register storage
  logic [7:0] nxt_regs [0:5]; // Next values
  localparam logic [7:0] BASE = `AGMD_ADDR_RESERVED; // First slot
  // Next values from write strobe
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    if (wr.we && wr.addr >= BASE && wr.addr <= `AGMD_ADDR_RMIX) begin
      if (wr.addr == `AGMD_ADDR_DRIVER) begin
        nxt_regs[1] = wr.data & `AGMD_DRIVER_WMASK;
      end else begin
        nxt_regs[3'(wr.addr - BASE)] = wr.data;
      end
    end
  end
  // Register the storage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      regs_ff[0] <= `AGMD_RST_RESERVED;
      regs_ff[1] <= `AGMD_RST_DRIVER;
      regs_ff[2] <= `AGMD_RST_GAIN;
      regs_ff[3] <= `AGMD_RST_GAIN;
      regs_ff[4] <= `AGMD_RST_MIX;
      regs_ff[5] <= `AGMD_RST_MIX;
    end else if (en_in) begin
      for (int i = 0; i < 6; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end
  assign rsvd_out = regs_ff[0];
  assign drv_out = regs_ff[1];
  assign lgain_out = regs_ff[2];
  assign rgain_out = regs_ff[3];
  assign lmix_out = regs_ff[4];
  assign rmix_out = regs_ff[5];
endmodule
`default_nettype wire

// *** tb/agmd_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "agmd_regs.svh"
// Port checks of the register slice
module agmd_chk (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic en_in, // Enable
  input wire logic we_in, // Write
  input wire logic re_in, // Read
  input wire logic [7:0] addr_in, // Slot
  input wire logic [7:0] wdata_in, // Data
  input wire logic headset_in, // Pin
  input wire logic [7:0] rdata_out, // Rdata
  input wire logic rvalid_out, // Rvalid
  input wire logic l_mute_out, // Lmute
  input wire logic [6:0] l_gain_out, // Lgain
  input wire logic r_mute_out, // Rmute
  input wire logic [6:0] r_gain_out, // Rgain
  input wire logic [3:0] conn_out, // Conn
  input wire logic [15:0] atten_out, // Atten
  input wire logic ac_coupled_out, // Coupling
  input wire logic full_diff_out, // Fdiff
  input wire logic pseudo_diff_out // Pdiff
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Saturated gain code
  function automatic logic [6:0] sat(input logic [6:0] v);
    return v > `AGMD_GAIN_SAT ? `AGMD_GAIN_SAT : v;
  endfunction
  // Shown attenuation steps
  function automatic logic [3:0] lv(input logic [3:0] v);
    return v > `AGMD_LVL_MAX ? `AGMD_LVL_MAX : v;
  endfunction
  // Write taken, then one running edge
  sequence s_wr(a);
    en_in && we_in && addr_in == a ##1 en_in;
  endsequence
  a_gain_sat: assert property (l_gain_out <= 7'h77 && r_gain_out <= 7'h77)
    else $error("gain above ceiling");
  a_lgain_code: assert property (s_wr(`AGMD_ADDR_LGAIN) |=>
    l_gain_out == sat($past(wdata_in[6:0], 2)) && l_mute_out == $past(wdata_in[7], 2))
    else $error("left gain wrong");
  a_rgain_code: assert property (s_wr(`AGMD_ADDR_RGAIN) |=>
    r_gain_out == sat($past(wdata_in[6:0], 2)) && r_mute_out == $past(wdata_in[7], 2))
    else $error("right gain wrong");
  a_lmix_dec: assert property (s_wr(`AGMD_ADDR_LMIX) |=>
    conn_out[1:0] == {$past(wdata_in[3:0], 2) != 4'hF, $past(wdata_in[7:4], 2) != 4'hF}
    && atten_out[7:0] == {lv($past(wdata_in[3:0], 2)), lv($past(wdata_in[7:4], 2))})
    else $error("left mixer wrong");
  a_rmix_dec: assert property (s_wr(`AGMD_ADDR_RMIX) |=>
    conn_out[3:2] == {$past(wdata_in[3:0], 2) != 4'hF, $past(wdata_in[7:4], 2) != 4'hF}
    && atten_out[15:8] == {lv($past(wdata_in[3:0], 2)), lv($past(wdata_in[7:4], 2))})
    else $error("right mixer wrong");
  a_drv_bits: assert property (s_wr(`AGMD_ADDR_DRIVER) |=>
    {ac_coupled_out, full_diff_out, pseudo_diff_out} == $past({wdata_in[7:6], wdata_in[3]}, 2))
    else $error("driver bits wrong");
  a_drv_rsvd: assert property (en_in && re_in && addr_in == 8'h0E |=>
    rvalid_out && rdata_out[5] == 1'b0 && rdata_out[2:0] == 3'h0)
    else $error("driver reserved bits set");
  a_unmap_zero: assert property (en_in && re_in && (addr_in < 8'h0D || addr_in > 8'h12)
    |=> rvalid_out && rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_rd_once: assert property (rvalid_out |-> $past(en_in && re_in))
    else $error("read valid without read");
  a_rst_state: assert property ($fell(rst_in) |-> l_mute_out && r_mute_out && conn_out == 4'h0)
    else $error("state after reset wrong");
  a_en_freeze: assert property (!en_in |=> $stable(conn_out) && $stable(l_gain_out))
    else $error("state moved while disabled");
endmodule
bind agmd_top agmd_chk u_chk (.clk_in, .rst_in, .en_in, .we_in, .re_in, .addr_in, .wdata_in,
  .headset_in, .rdata_out, .rvalid_out, .l_mute_out, .l_gain_out, .r_mute_out, .r_gain_out,
  .conn_out, .atten_out, .ac_coupled_out, .full_diff_out, .pseudo_diff_out);
`default_nettype wire

// *** tb/adc_gain_mix_and_driver_config_regs_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench of the slice
module adc_gain_mix_and_driver_config_regs_bench;
  logic clk_in, rst_in, en_in, we_in, re_in, headset_in; // Drives
  logic [7:0] addr_in, wdata_in, rdata_out; // Bus
  logic rvalid_out, l_mute_out, r_mute_out, ac_coupled_out, full_diff_out, pseudo_diff_out;
  logic [6:0] l_gain_out, r_gain_out; // Gains
  logic [3:0] conn_out, c; // Connects, expected steps
  logic [15:0] atten_out; // Steps
  logic [6:0] gc[6] = '{7'h00, 7'h01, 7'h76, 7'h77, 7'h78, 7'h7F}; // Gain codes
  logic [3:0] lc[5] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'hF}; // Level codes, no 9..14
  int n_mismatch, n_checks; // Counters
  agmd_top uut (.clk_in, .rst_in, .en_in, .we_in, .re_in, .addr_in, .wdata_in, .headset_in,
    .rdata_out, .rvalid_out, .l_mute_out, .l_gain_out, .r_mute_out, .r_gain_out, .conn_out,
    .atten_out, .ac_coupled_out, .full_diff_out, .pseudo_diff_out);
  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Compare one value
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // One write, returns once decoded outputs settle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {we_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge clk_in);
    we_in <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  // One read and its answer
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    {re_in, addr_in} <= {1'b1, a};
    @(posedge clk_in);
    re_in <= 1'b0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, rvalid_out});
    chk("rdata", {8'h00, e}, {8'h00, rdata_out});
  endtask
  // Verdict and end of run
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_in, en_in, we_in, re_in, headset_in} = 5'h18;
    {addr_in, wdata_in} = 16'h0000;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(8'h0D, 8'h00);
    rd(8'h0E, 8'h00);
    rd(8'h0F, 8'h80);
    rd(8'h10, 8'h80);
    rd(8'h11, 8'hFF);
    rd(8'h12, 8'hFF);
    rd(8'h20, 8'h00);
    chk("atten", 16'h8888, atten_out);
    chk("conn", 16'h0000, {12'h000, conn_out});
    foreach (gc[i]) begin
      wr(8'h0F, {1'b0, gc[i]});
      chk("lgain", {9'h000, (gc[i] > 7'h77 ? 7'h77 : gc[i])}, {9'h000, l_gain_out});
      chk("lmute", 16'h0000, {15'h0000, l_mute_out});
      wr(8'h10, {1'b1, gc[i]});
      chk("rgain", {9'h000, (gc[i] > 7'h77 ? 7'h77 : gc[i])}, {9'h000, r_gain_out});
      chk("rmute", 16'h0001, {15'h0000, r_mute_out});
    end
    foreach (lc[i]) begin
      wr(8'h11, {lc[i], 4'hF});
      wr(8'h12, {4'hF, lc[i]});
      c = lc[i] > 4'h8 ? 4'h8 : lc[i];
      chk("conn", {12'h000, lc[i] != 4'hF, 2'h0, lc[i] != 4'hF}, {12'h000, conn_out});
      chk("atten", {c, 8'h88, c}, atten_out);
      rd(8'h11, {lc[i], 4'hF});
    end
    @(posedge clk_in);
    headset_in <= 1'b1;
    wr(8'h0E, 8'h90);
    chk("ac", 16'h0001, {15'h0000, ac_coupled_out});
    rd(8'h0E, 8'h90);
    wr(8'h0E, 8'h40);
    chk("fdiff", 16'h0001, {15'h0000, full_diff_out});
    wr(8'h0E, 8'h18);
    chk("pdiff", 16'h0001, {15'h0000, pseudo_diff_out});
    @(posedge clk_in);
    headset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rd(8'h0E, 8'h08);
    wr(8'h0D, 8'h00);
    rd(8'h0D, 8'h00);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    wr(8'h0F, 8'h05);
    @(posedge clk_in);
    en_in <= 1'b0;
    wr(8'h0F, 8'h3C);
    @(posedge clk_in);
    en_in <= 1'b1;
    rd(8'h0F, 8'h05);
    chk("lgain", 16'h0005, {9'h000, l_gain_out});
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(8'h0F, 8'h80);
    summarize;
  end
  // Watchdog against a hang
  initial begin
    repeat (2000) @(posedge clk_in);
    n_mismatch++;
    summarize;
  end
endmodule
`default_nettype wire
